// ==== core/cafl_event_module.sv ====
// cafl_event_module: one compare/capture module, raises a one-cycle event
// assumes the io pin is synchronous to clk
`timescale 1ns/1ps
module cafl_event_module
    import cafl_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic match_mode,
    input wire logic rise_capture_en,
    input wire logic [cafl_pkg::CAFL_CW-1:0] count,
    input wire logic [cafl_pkg::CAFL_CW-1:0] compare_value,
    input wire logic count_step,
    input wire logic module_io_pin,
    output logic event_pulse
);
    logic pin_q;
    logic pin_d;

    always_comb begin
        pin_d = module_io_pin;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    // match on the count just reached, capture on rising pin edge
    always_comb begin
        event_pulse = (match_mode && count_step && (count == compare_value)) // [R9]
            || (rise_capture_en && module_io_pin && !pin_q); // [R10]
    end
endmodule : cafl_event_module

// ==== core/cafl_pkg.sv ====
// cafl_pkg: register map, field positions and reset values of the counter array flags block
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package cafl_pkg;
    localparam int CAFL_NMOD = 5;
    localparam int CAFL_AW = 8;
    localparam int CAFL_CW = 16;
    // register byte offsets
    localparam logic [7:0] CAFL_OFF_CTRL_STATUS = 8'h00;
    localparam logic [7:0] CAFL_OFF_MODE = 8'h04;
    localparam logic [7:0] CAFL_OFF_MOD_MODE0 = 8'h08;
    localparam logic [7:0] CAFL_OFF_CAPCMP0 = 8'h1C;
    localparam logic [7:0] CAFL_OFF_COUNT = 8'h30;
    localparam logic [7:0] CAFL_OFF_IRQ_STATUS = 8'h34;
    localparam logic [7:0] CAFL_OFF_IRQ_MASK = 8'h38;
    // control/status fields
    localparam int CAFL_BIT_OVF = 7;
    localparam int CAFL_BIT_RUN = 6;
    localparam int CAFL_BIT_RSVD = 5;
    // mode register fields
    localparam int CAFL_BIT_OVF_IE = 0;
    // module mode fields
    localparam int CAFL_BIT_RISE_CAP = 5;
    localparam int CAFL_BIT_MATCH = 3;
    localparam int CAFL_BIT_EV_IE = 0;
    // reset values
    localparam logic [7:0] CAFL_RST_CTRL = 8'h00;
    localparam logic [7:0] CAFL_RST_MODE = 8'h00;
    localparam logic [7:0] CAFL_RST_MOD_MODE = 8'h00;
    localparam logic [5:0] CAFL_RST_IRQ = 6'h00;
    localparam logic [CAFL_CW-1:0] CAFL_RST_COUNT = 16'h0000;
    localparam logic [CAFL_CW-1:0] CAFL_COUNT_MAX = 16'hFFFF;
    // reserved bit reads as this constant
    localparam logic CAFL_RSVD_READ = 1'b0;
    typedef enum logic [1:0] {
        CAFL_BUS_IDLE = 2'b01,
        CAFL_BUS_ACK = 2'b10
    } cafl_bus_t;
endpackage : cafl_pkg

// ==== core/cafl_top.sv ====
// cafl_top: run control, overflow and module event flags of a five-module counter array
// assumes an avalon-mm master with waitrequest on clk; io pins synchronous to clk
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps

// Behaviour
// R1: overflow sets flag; only software clears
// R2: counter runs only while run bit set
// R3: run bit clear halts, count held
// R4: software writes zero to reserved bit
// R5: reserved bit reads a constant
// R6: module event flag sticky until software clears
// R7: overflow flag interrupts when enabled
// R8: module flag interrupts when enabled
// R9: match mode equality sets event flag; code sets it only while run bit set
// R10: rising pin edge capture sets flag
module cafl_top
    import cafl_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [cafl_pkg::CAFL_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [cafl_pkg::CAFL_NMOD-1:0] module_io_pin,
    output logic [cafl_pkg::CAFL_CW-1:0] count_out,
    output logic counter_irq,
    output logic irq
);
    import cafl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic run_q, run_d;
    logic ovf_q, ovf_d;
    logic [CAFL_NMOD-1:0] evf_q, evf_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] mmode_q [CAFL_NMOD];
    logic [7:0] mmode_d [CAFL_NMOD];
    logic [CAFL_CW-1:0] cmp_q [CAFL_NMOD];
    logic [CAFL_CW-1:0] cmp_d [CAFL_NMOD];
    logic [CAFL_CW-1:0] cnt_q, cnt_d;
    logic [5:0] ists_q, ists_d;
    logic [5:0] imsk_q, imsk_d;
    logic [31:0] rdata_q, rdata_d;
    cafl_bus_t bus_q, bus_d;
    logic [CAFL_NMOD-1:0] ev_pulse;
    logic ovf_pulse;
    logic wr_en;
    logic rd_en;
    logic take;
    logic accept;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_cnt;
    logic wr_ists;
    logic wr_imsk;
    logic [CAFL_NMOD-1:0] wr_mmode;
    logic [CAFL_NMOD-1:0] wr_cmp;

    function automatic logic [CAFL_CW-1:0] cw_merge(input logic [CAFL_CW-1:0] old,
                                                    input logic [31:0] wd,
                                                    input logic [3:0] be);
        logic [CAFL_CW-1:0] r;
        r = old;
        if (be[0]) r[7:0] = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : cw_merge

    // byte offset of register idx in a per-module bank
    function automatic logic [CAFL_AW-1:0] mod_offset(input logic [CAFL_AW-1:0] base,
                                                      input int idx);
        return base + CAFL_AW'(4 * idx);
    endfunction : mod_offset

    // true when addr selects register idx of a per-module bank
    function automatic logic mod_hit(input logic [CAFL_AW-1:0] addr,
                                     input logic [CAFL_AW-1:0] base,
                                     input int idx);
        return addr == mod_offset(base, idx);
    endfunction : mod_hit

    ////////////////////////////////////////////////////////////////////////////////
    // counter and events
    always_comb begin
        ovf_pulse = run_q && (cnt_q == CAFL_COUNT_MAX);
    end

    for (genvar i = 0; i < CAFL_NMOD; i++) begin : g_mod
        cafl_event_module u_mod (
            .clk(clk),
            .arst_n(arst_n),
            .match_mode(mmode_q[i][CAFL_BIT_MATCH]),
            .rise_capture_en(mmode_q[i][CAFL_BIT_RISE_CAP]),
            .count(cnt_q),
            .compare_value(cmp_q[i]),
            .count_step(run_q),
            .module_io_pin(module_io_pin[i]),
            .event_pulse(ev_pulse[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: taken when idle, accepted one cycle later
    always_comb begin
        take = 1'b0;
        accept = 1'b0;
        bus_d = bus_q;
        case (bus_q)
            CAFL_BUS_IDLE: begin
                take = avs_read || avs_write;
                if (take) begin
                    bus_d = CAFL_BUS_ACK;
                end
            end
            CAFL_BUS_ACK: begin
                accept = avs_read || avs_write;
                bus_d = CAFL_BUS_IDLE;
            end
            default: begin
                bus_d = CAFL_BUS_IDLE;
            end
        endcase
        // writes land on the accepting edge, read data is latched on the taking edge
        wr_en = accept && avs_write;
        rd_en = take && avs_read;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q <= CAFL_BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write decode
    always_comb begin
        wr_ctrl = wr_en && avs_byteenable[0] && (avs_address == CAFL_OFF_CTRL_STATUS);
        wr_mode = wr_en && avs_byteenable[0] && (avs_address == CAFL_OFF_MODE);
        wr_ists = wr_en && avs_byteenable[0] && (avs_address == CAFL_OFF_IRQ_STATUS);
        wr_imsk = wr_en && avs_byteenable[0] && (avs_address == CAFL_OFF_IRQ_MASK);
        wr_cnt = wr_en && (avs_address == CAFL_OFF_COUNT);
        for (int i = 0; i < CAFL_NMOD; i++) begin
            wr_mmode[i] = wr_en && avs_byteenable[0]
                && mod_hit(avs_address, CAFL_OFF_MOD_MODE0, i);
            wr_cmp[i] = wr_en && mod_hit(avs_address, CAFL_OFF_CAPCMP0, i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter
    always_comb begin
        cnt_d = cnt_q; // [R3]
        if (run_q) begin
            cnt_d = cnt_q + 1'b1; // [R2]
        end
        if (wr_cnt) begin
            cnt_d = cw_merge(cnt_q, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= CAFL_RST_COUNT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // run control and flags
    always_comb begin
        run_d = run_q;
        ovf_d = ovf_q;
        evf_d = evf_q;
        if (wr_ctrl) begin
            run_d = avs_writedata[CAFL_BIT_RUN]; // [R2] [R3]
            ovf_d = avs_writedata[CAFL_BIT_OVF];
            evf_d = avs_writedata[CAFL_NMOD-1:0];
        end
        // hardware sets win over software clears
        if (ovf_pulse) begin
            ovf_d = 1'b1; // [R1]
        end
        evf_d = evf_d | ev_pulse; // [R6]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= CAFL_RST_CTRL[CAFL_BIT_RUN];
            ovf_q <= CAFL_RST_CTRL[CAFL_BIT_OVF];
            evf_q <= CAFL_RST_CTRL[CAFL_NMOD-1:0];
        end else begin
            run_q <= run_d;
            ovf_q <= ovf_d;
            evf_q <= evf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode registers
    always_comb begin
        mode_d = mode_q;
        mmode_d = mmode_q;
        if (wr_mode) begin
            mode_d = avs_writedata[7:0];
        end
        for (int i = 0; i < CAFL_NMOD; i++) begin
            if (wr_mmode[i]) begin
                mmode_d[i] = avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= CAFL_RST_MODE;
            for (int i = 0; i < CAFL_NMOD; i++) begin
                mmode_q[i] <= CAFL_RST_MOD_MODE;
            end
        end else begin
            mode_q <= mode_d;
            mmode_q <= mmode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare values
    always_comb begin
        cmp_d = cmp_q;
        for (int i = 0; i < CAFL_NMOD; i++) begin
            if (wr_cmp[i]) begin
                cmp_d[i] = cw_merge(cmp_q[i], avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < CAFL_NMOD; i++) begin
                cmp_q[i] <= CAFL_RST_COUNT;
            end
        end else begin
            cmp_q <= cmp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    always_comb begin
        ists_d = ists_q;
        imsk_d = imsk_q;
        if (wr_ists) begin
            ists_d = ists_q & ~avs_writedata[5:0];
        end
        if (wr_imsk) begin
            imsk_d = avs_writedata[5:0];
        end
        // a new event wins over a clear in the same cycle
        ists_d = ists_d | {ovf_pulse, ev_pulse};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ists_q <= CAFL_RST_IRQ;
            imsk_q <= CAFL_RST_IRQ;
        end else begin
            ists_q <= ists_d;
            imsk_q <= imsk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        rdata_d = rdata_q;
        if (rd_en) begin
            case (avs_address)
                CAFL_OFF_CTRL_STATUS: rdata_d = {24'h000000, ovf_q, run_q,
                                                 CAFL_RSVD_READ, evf_q}; // [R5]
                CAFL_OFF_MODE: rdata_d = {24'h000000, mode_q};
                CAFL_OFF_COUNT: rdata_d = {16'h0000, cnt_q};
                CAFL_OFF_IRQ_STATUS: rdata_d = {26'h0000000, ists_q};
                CAFL_OFF_IRQ_MASK: rdata_d = {26'h0000000, imsk_q};
                default: begin
                    rdata_d = 32'h00000000;
                    for (int i = 0; i < CAFL_NMOD; i++) begin
                        if (mod_hit(avs_address, CAFL_OFF_MOD_MODE0, i)) begin
                            rdata_d = {24'h000000, mmode_q[i]};
                        end
                        if (mod_hit(avs_address, CAFL_OFF_CAPCMP0, i)) begin
                            rdata_d = {16'h0000, cmp_q[i]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        logic req;
        req = ovf_q && mode_q[CAFL_BIT_OVF_IE]; // [R7]
        for (int i = 0; i < CAFL_NMOD; i++) begin
            req = req || (evf_q[i] && mmode_q[i][CAFL_BIT_EV_IE]); // [R8]
        end
        counter_irq = req;
        irq = |(ists_q & imsk_q);
        avs_waitrequest = (avs_read || avs_write) && (bus_q != CAFL_BUS_ACK);
        avs_readdata = rdata_q;
        count_out = cnt_q;
    end
endmodule : cafl_top

// ==== dv/cafl_top_props.sv ====
// cafl_top_props: port checks of the counter array flags block
// assumes bind to cafl_top, one clock, async active-low reset
`timescale 1ns/1ps
module cafl_top_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [cafl_pkg::CAFL_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [cafl_pkg::CAFL_CW-1:0] count_out,
    input wire logic counter_irq,
    input wire logic irq
);
    import cafl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    a_read_stands: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'hFC
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_count_held: assert property (count_out == $past(count_out) && !avs_write
        && !$past(avs_write) |=> $stable(count_out)) else $error("halted counter moved");
    a_count_runs: assert property (count_out == 16'($past(count_out) + 1'b1) && !avs_write
        && !$past(avs_write) |=> count_out == 16'($past(count_out) + 1'b1))
        else $error("running counter stopped");
    a_flag_sticky: assert property (counter_irq && !avs_write |=> counter_irq)
        else $error("flag interrupt dropped without a write");
    a_irq_sticky: assert property (irq && !avs_write |=> irq)
        else $error("irq dropped without a write");
endmodule : cafl_top_props

// ==== dv/tb_cafl_top.sv ====
// tb_cafl_top: register-level test of the counter array flags block
// assumes cafl_top with the package register map
`timescale 1ns/1ps
module tb_cafl_top;
    import cafl_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] module_io_pin = 5'h00;
    logic [15:0] count_out;
    logic counter_irq;
    logic irq;
    logic [31:0] rd_q;
    logic [31:0] a_q;
    int mismatches = 0;
    int compares = 0;
    cafl_top u_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .module_io_pin(module_io_pin),
        .count_out(count_out), .counter_irq(counter_irq), .irq(irq));
    initial begin
        forever #50 clk = ~clk;
    end
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic w;
        n = 0;
        w = 1'b1;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        while (w !== 1'b0 && n < 20) begin
            @(posedge clk);
            w = avs_waitrequest;
            rd_q = avs_readdata;
            n++;
        end
        if (w !== 1'b0) begin
            mismatches++;
            $display("[FAIL] waitrequest exp 0 got %b", w);
            report_and_stop();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd_q & m);
    endtask : rdc
    task irqs(input string nm, input logic [1:0] e);
        @(negedge clk);
        chk(nm, {30'h0, e}, {30'h0, counter_irq, irq});
    endtask : irqs
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rdc("ctrl", CAFL_OFF_CTRL_STATUS, 32'h0, 32'hDF);
        rdc("count", CAFL_OFF_COUNT, 32'h0, 32'hFFFF);
        bus(1'b1, 8'hFC, 32'hFF);
        rdc("unmapped", 8'hFC, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h40);
        repeat (5) @(posedge clk);
        rdc("run", CAFL_OFF_CTRL_STATUS, 32'h40, 32'hDF);
        bus(1'b0, CAFL_OFF_COUNT, 32'h0);
        a_q = rd_q;
        rdc("counting", CAFL_OFF_COUNT, 32'h0, 32'hFFFF0000);
        chk("counting", 32'h1, {31'h0, rd_q[15:0] != a_q[15:0]});
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h0);
        rdc("stop", CAFL_OFF_COUNT, 32'h0, 32'hFFFF0000);
        a_q = rd_q & 32'hFFFF;
        repeat (5) @(posedge clk);
        rdc("held", CAFL_OFF_COUNT, a_q, 32'hFFFF);
        chk("count_pin", a_q, {16'h0000, count_out});
        avs_byteenable <= 4'h0;
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h40);
        avs_byteenable <= 4'hF;
        rdc("no_lane", CAFL_OFF_CTRL_STATUS, 32'h0, 32'hDF);
        $display("done run_stop");
        bus(1'b1, CAFL_OFF_MODE, 32'h1);
        bus(1'b1, CAFL_OFF_COUNT, 32'hFFF8);
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h40);
        repeat (12) @(posedge clk);
        rdc("ovf_set", CAFL_OFF_CTRL_STATUS, 32'hC0, 32'hC0);
        irqs("ovf_irq", 2'b10);
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h80);
        rdc("ovf_kept", CAFL_OFF_CTRL_STATUS, 32'h80, 32'hDF);
        bus(1'b1, CAFL_OFF_MODE, 32'h0);
        irqs("ovf_off", 2'b00);
        bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h0);
        rdc("ovf_clr", CAFL_OFF_CTRL_STATUS, 32'h0, 32'hDF);
        bus(1'b1, CAFL_OFF_IRQ_STATUS, 32'h3F);
        $display("done overflow");
        for (int i = 0; i < CAFL_NMOD; i++) begin
            bus(1'b1, 8'(CAFL_OFF_MOD_MODE0 + 4 * i), 32'h09);
            bus(1'b1, 8'(CAFL_OFF_CAPCMP0 + 4 * i), 32'h10);
            bus(1'b1, CAFL_OFF_COUNT, 32'h0);
            bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h40);
            repeat (25) @(posedge clk);
            rdc("match", CAFL_OFF_CTRL_STATUS, 32'h40 | (32'h1 << i), 32'hDF);
            irqs("match_irq", 2'b10);
            bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h0);
            rdc("match_clr", CAFL_OFF_CTRL_STATUS, 32'h0, 32'hDF);
            bus(1'b1, 8'(CAFL_OFF_MOD_MODE0 + 4 * i), 32'h20);
            module_io_pin[i] <= 1'b1;
            repeat (3) @(posedge clk);
            rdc("capture", CAFL_OFF_CTRL_STATUS, 32'h1 << i, 32'hDF);
            irqs("cap_irq", 2'b00);
            rdc("irq_stat", CAFL_OFF_IRQ_STATUS, 32'h1 << i, 32'h1 << i);
            bus(1'b1, CAFL_OFF_IRQ_MASK, 32'h1 << i);
            irqs("irq_on", 2'b01);
            bus(1'b1, CAFL_OFF_IRQ_STATUS, 32'h3F);
            irqs("irq_clr", 2'b00);
            bus(1'b1, CAFL_OFF_IRQ_MASK, 32'h0);
            bus(1'b1, CAFL_OFF_CTRL_STATUS, 32'h0);
            module_io_pin[i] <= 1'b0;
            bus(1'b1, 8'(CAFL_OFF_MOD_MODE0 + 4 * i), 32'h0);
        end
        $display("done modules");
        report_and_stop();
    end
endmodule : tb_cafl_top
bind cafl_top cafl_top_props u_props (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_out(count_out), .counter_irq(counter_irq), .irq(irq));
